//--- idm_cfg.svh
// Constants for the internal data memory map.
// Included by the package and by the design modules.
`ifndef IDM_CFG_SVH
`define IDM_CFG_SVH
`define IDM_DEPTH 256
`define IDM_ADDR_W 8
`define IDM_DATA_W 8
`define IDM_LOW_TOP 8'h7f
`define IDM_BANK_TOP 8'h1f
`define IDM_REGS_PER_BANK 8
`define IDM_BIT_BASE 8'h20
`define IDM_BIT_TOP 8'h2f
`define IDM_BIT_COUNT 128
`define IDM_RESET_VALUE 8'h00
`endif

//--- idm_pkg.sv
// Types for the internal data memory map.
// Assumes idm_cfg.svh is on the include path.
`include "idm_cfg.svh"
package idm_pkg;
    typedef enum logic [1:0]
    {
        ACC_DIRECT,
        ACC_INDIRECT,
        ACC_BIT,
        ACC_WORKREG
    } acc_kind_t;
    typedef logic [7:0] byte_t;
endpackage

//--- idm_ram.sv
// Storage array of the internal data memory: one write port with a
// per-bit mask, one registered read port.
// Assumes the map decoder gives it legal addresses only.
`timescale 1ns/1ps
`include "idm_cfg.svh"
module idm_ram
    import idm_pkg::*;
#(
    parameter int DEPTH = `IDM_DEPTH
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [7:0] wrAddr,
    input wire logic [7:0] wrMask,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdAddr,
    output logic [7:0] rdData
);
    // Eight address bits reach exactly this many bytes
    if (DEPTH != `IDM_DEPTH)
        $error("idm_ram: depth must match the 8-bit address");

    byte_t mem [DEPTH];

    // No reset on the array; contents are undefined until written
    always_ff @(posedge mclk)
    begin
        if (wrEn)
            mem[wrAddr] <= (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdData <= `IDM_RESET_VALUE;
        else
            rdData <= mem[rdAddr];
    end
endmodule

//--- internal_data_memory_map.sv
// Address map of the internal data memory: RAM, SFR split, banks, bits.
// Assumes one access per cycle from the core; SFR space lives outside.
`timescale 1ns/1ps
`include "idm_cfg.svh"
module internal_data_memory_map
    import idm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic accValid,
    input wire logic accWrite,
    input wire acc_kind_t accKind,
    input wire logic [7:0] accAddr,
    input wire logic [7:0] accWrData,
    input wire logic bankSelectLow,
    input wire logic bankSelectHigh,
    output logic [7:0] rdData,
    output logic rdBit,
    output logic rdValid,
    output logic sfrSel,
    output logic sfrWrite,
    output logic [7:0] sfrAddr,
    output logic [7:0] sfrWrData,
    input wire logic [7:0] sfrRdData
);
    // Bit address to byte address in the bit area
    function automatic logic [7:0] bitByte(input logic [7:0] k);
        bitByte = `IDM_BIT_BASE + {4'h0, k[6:3]};
    endfunction

    logic [1:0] bankIdx;
    logic toSfr;
    logic [7:0] ramAddr;
    logic [7:0] ramMask;
    logic [7:0] ramWrData;
    logic ramWrEn;
    logic [7:0] ramRdData;
    logic isBit;
    logic bitInRange;
    logic sfrPending_q;
    logic bitPending_q;
    logic [2:0] bitSel_q;
    logic rdValid_q;

    assign bankIdx = {bankSelectHigh, bankSelectLow};
    assign isBit = (accKind == ACC_BIT);
    // Bit addresses above 0x7f belong to SFR bit space
    assign bitInRange = (accAddr[7] == 1'b0);

    always_comb
    begin
        toSfr = 1'b0;
        ramAddr = accAddr;
        ramMask = 8'hff;
        ramWrData = accWrData;
        unique case (accKind)
            ACC_DIRECT:
                toSfr = (accAddr > `IDM_LOW_TOP);
            ACC_INDIRECT:
                ramAddr = accAddr;
            ACC_WORKREG:
                ramAddr = {3'h0, bankIdx, accAddr[2:0]};
            ACC_BIT:
            begin
                toSfr = ~bitInRange;
                ramAddr = bitByte(accAddr);
                ramMask = 8'h01 << accAddr[2:0];
                ramWrData = {8{accWrData[0]}};
            end
        endcase
    end

    assign ramWrEn = accValid && accWrite && !toSfr;
    assign sfrSel = accValid && toSfr;
    assign sfrWrite = accValid && accWrite && toSfr;
    assign sfrAddr = accAddr;
    assign sfrWrData = accWrData;

    idm_ram u_ram
    (
        .mclk(mclk),
        .rst(rst),
        .wrEn(ramWrEn),
        .wrAddr(ramAddr),
        .wrMask(ramMask),
        .wrData(ramWrData),
        .rdAddr(ramAddr),
        .rdData(ramRdData)
    );

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sfrPending_q <= 1'b0;
            bitPending_q <= 1'b0;
            bitSel_q <= 3'h0;
        end
        else
        begin
            sfrPending_q <= toSfr;
            bitPending_q <= isBit;
            bitSel_q <= accAddr[2:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdValid_q <= 1'b0;
        else
            rdValid_q <= accValid && !accWrite;
    end
    assign rdValid = rdValid_q;

    // SFR data arrives from outside in the answer cycle
    assign rdData = sfrPending_q ? sfrRdData : ramRdData;
    // Bit reads see only the addressed bit
    assign rdBit = bitPending_q ? rdData[bitSel_q] : 1'b0;

    // Routing is checked in the request cycle, answers one cycle later
    a_sfr_split: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && accKind == ACC_DIRECT && accAddr[7]
        |-> sfrSel && !ramWrEn)
        else $error("Direct upper access not routed to SFR");

    a_low_ram: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && accKind != ACC_BIT && !accAddr[7]
        && accKind != ACC_WORKREG |-> !sfrSel && ramAddr == accAddr)
        else $error("Low half access not routed to RAM");

    a_indirect_ram: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && accKind == ACC_INDIRECT |-> !sfrSel)
        else $error("Indirect access left RAM");

    a_ind_upper: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && accKind == ACC_INDIRECT && accAddr[7]
        |-> ramAddr == accAddr && ramWrEn == accWrite)
        else $error("Indirect upper access not routed to RAM");

    a_bank_map: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && accKind == ACC_WORKREG
        |-> ramAddr == {3'h0, bankSelectHigh, bankSelectLow,
            accAddr[2:0]} && ramAddr <= `IDM_BANK_TOP && !sfrSel)
        else $error("Work register address wrong");

    a_bank_sel: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && accKind == ACC_WORKREG && bankSelectHigh
        |-> ramAddr[4])
        else $error("High select bit not upper bank bit");

    a_bit_byte: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && isBit && !accAddr[7]
        |-> ramAddr >= `IDM_BIT_BASE && ramAddr <= `IDM_BIT_TOP)
        else $error("Bit byte outside bit area");

    a_bit_sfr: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && isBit && accAddr[7] |-> sfrSel && !ramWrEn)
        else $error("Upper bit address reached RAM");

    a_bit_pos: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && isBit && !accAddr[7] |-> ramMask == (8'h01 <<
            accAddr[2:0]) && ramAddr[3:0] == accAddr[6:3])
        else $error("Bit position wrong");

    a_bit_keep: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && accWrite && isBit |-> $onehot(ramMask)
        && (ramWrData & ramMask) == ({8{accWrData[0]}} & ramMask))
        else $error("Bit write touches more than one bit");

    a_bit_read: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && !accWrite && isBit
        |=> rdValid && rdBit == rdData[$past(accAddr[2:0])])
        else $error("Bit read returns wrong bit");

    a_byte_nobit: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && !isBit |=> !rdBit)
        else $error("Bit output set after a byte access");

    a_rd_valid: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && !accWrite |=> rdValid)
        else $error("Read answer missing");

    a_no_valid: assert property (@(posedge mclk)
        disable iff (rst)
        !accValid || accWrite |=> !rdValid)
        else $error("Read answer without a read");

    a_idle_quiet: assert property (@(posedge mclk)
        disable iff (rst)
        !accValid
        |-> !sfrSel && !sfrWrite && !ramWrEn)
        else $error("Idle cycle reached memory or SFR port");

    a_sfr_answer: assert property (@(posedge mclk)
        disable iff (rst)
        accValid && !accWrite && sfrSel |=> rdData == sfrRdData)
        else $error("SFR read data not passed through");

    a_sfr_fwd: assert property (@(posedge mclk)
        disable iff (rst)
        sfrSel
        |-> sfrAddr == accAddr && sfrWrite == accWrite
        && (!sfrWrite || sfrWrData == accWrData))
        else $error("SFR port does not carry the access");

    c_sfr: cover property (@(posedge mclk) sfrSel && !sfrWrite);
    c_bit_rd: cover property (@(posedge mclk)
        accValid && !accWrite && isBit && !accAddr[7]);
    c_bit_wr: cover property (@(posedge mclk)
        accValid && accWrite && isBit);
    c_bank3: cover property (@(posedge mclk)
        accValid && accKind == ACC_WORKREG && bankIdx == 2'h3);
    c_ind_hi: cover property (@(posedge mclk)
        accValid && accKind == ACC_INDIRECT && accAddr[7]);
endmodule

//--- internal_data_memory_map_tb.sv
// Self-checking bench for the internal data memory map.
// Assumes the SFR model answers one cycle after the select.
`timescale 1ns/1ps
module internal_data_memory_map_tb;
    import idm_pkg::*;
    logic mclk, rst, accValid, accWrite, bSelLo, bSelHi, rdBit, rdValid;
    logic sfrSel, sfrWrite;
    acc_kind_t accKind, k;
    logic [7:0] accAddr, accWrData, rdData, sfrAddr, sfrWrData, sfrRdData;
    logic [7:0] a;
    int errTotal = 0;
    int samplesChecked = 0;
    int seed = 32;
    // Slots 0-255 RAM, 256-511 SFR space
    logic [7:0] m [512];
    internal_data_memory_map DUT (.mclk(mclk), .rst(rst),
        .accValid(accValid), .accWrite(accWrite), .accKind(accKind),
        .accAddr(accAddr), .accWrData(accWrData),
        .bankSelectLow(bSelLo), .bankSelectHigh(bSelHi),
        .rdData(rdData), .rdBit(rdBit), .rdValid(rdValid),
        .sfrSel(sfrSel), .sfrWrite(sfrWrite), .sfrAddr(sfrAddr),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData));
    sfr_space_model sfr (.mclk(mclk), .sfrSel(sfrSel),
        .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
        .sfrRdData(sfrRdData));
    task automatic chkBit(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic int slot(acc_kind_t kd, logic [7:0] ad,
                                logic [1:0] b);
        case (kd)
            ACC_DIRECT: return ad[7] ? 256 + ad : ad;
            ACC_INDIRECT: return ad;
            ACC_BIT: return 32 + ad[6:3];
            default: return b * 8 + ad[2:0];
        endcase
    endfunction
    task automatic acc(input logic w, input acc_kind_t kd,
                       input logic [7:0] ad, input logic [7:0] d);
        int i;
        logic [1:0] b;
        logic s;
        b = 2'($random(seed));
        i = slot(kd, ad, b);
        s = (kd == ACC_DIRECT || kd == ACC_BIT) && ad[7];
        @(posedge mclk);
        accValid <= 1'b1;
        accWrite <= w;
        accKind <= kd;
        accAddr <= ad;
        accWrData <= d;
        bSelHi <= b[1];
        bSelLo <= b[0];
        #1;
        chkBit(sfrSel, s);
        chkBit(sfrWrite, s && w);
        chk(sfrAddr, ad);
        if (w)
            chk(sfrWrData, d);
        @(posedge mclk);
        accValid <= 1'b0;
        #1;
        if (w)
        begin
            chkBit(rdValid, 1'b0);
            if (kd == ACC_BIT)
                m[i][ad[2:0]] = d[0];
            else
                m[i] = d;
        end
        else
        begin
            chkBit(rdValid, 1'b1);
            if (kd == ACC_BIT)
                chkBit(rdBit, m[i][ad[2:0]]);
            else
            begin
                chk(rdData, m[i]);
                chkBit(rdBit, 1'b0);
            end
        end
    endtask
    task automatic close_out();
        $display("checked=%0d bad=%0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial
    begin
        #60000;
        errTotal++;
        close_out();
    end
    initial
    begin
        {rst, accValid, accWrite, bSelLo, bSelHi} = 5'h10;
        accKind = ACC_DIRECT;
        accAddr = 8'h00;
        accWrData = 8'h00;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        for (int j = 0; j < 384; j++)
        begin
            a = (j < 256) ? 8'(j) : 8'(j - 128);
            k = (j < 256) ? ACC_INDIRECT : ACC_DIRECT;
            acc(1'b1, k, a, 8'($random(seed)));
        end
        acc(1'b1, ACC_BIT, 8'h42, 8'h01);
        acc(1'b0, ACC_INDIRECT, 8'h28, 8'h00);
        $display("fill done");
        // Mid-run reset: outputs clear, array contents must survive
        rst <= 1'b1;
        @(posedge mclk);
        #1;
        chkBit(rdValid, 1'b0);
        chk(rdData, 8'h00);
        rst <= 1'b0;
        $display("reset done");
        repeat (400)
        begin
            k = acc_kind_t'(2'($random(seed)));
            a = 8'($random(seed));
            if (k == ACC_BIT)
                a = a & 8'h7f;
            acc(1'($random(seed)), k, a, 8'($random(seed)));
        end
        $display("random done");
        close_out();
    end
endmodule

//--- sfr_space_model.sv
// SFR space model on the map's SFR port.
// Assumes read data is wanted the cycle after the select.
`timescale 1ns/1ps
module sfr_space_model
(
    input wire logic mclk,
    input wire logic sfrSel,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData
);
    logic [7:0] regs [256];
    logic [7:0] addrQ;
    logic selQ;
    always_ff @(posedge mclk)
    begin
        if (sfrSel && sfrWrite)
            regs[sfrAddr] <= sfrWrData;
        addrQ <= sfrAddr;
        selQ <= sfrSel;
    end
    // Unselected: inverted, so stale data never passes
    assign sfrRdData = selQ ? regs[addrQ] : ~regs[addrQ];
endmodule
